// ===== dac_ctrl_pkg.sv
// Purpose: shared constants of the octal converter serial control block
// Assumes: fourteen-bit frames, eight channels of ten-bit codes
// Notes: address bits arrive reversed; see the decode in the top module
package dac_ctrl_pkg;
  localparam int NCH = 8;
  localparam int FRAME_W = 14;
  localparam int PAY_W = 10;
  localparam int ADDR_W = 4;
  localparam int ADDR_LSB_POS = 13;
  localparam int ADDR_MSB_POS = 10;
  localparam int CHAN_SEL_W = 3;
  localparam logic [3:0] ADDR_CHAN_FIRST = 4'h1;
  localparam logic [3:0] ADDR_CHAN_LAST = 4'h8;
  localparam logic [3:0] ADDR_POWER_OFF = 4'h9;
  localparam logic [3:0] ADDR_CONTROL = 4'hA;
  localparam int CTRL_RESET_BIT = 5;
  localparam int CTRL_UPDATE_BIT = 4;
  localparam int CTRL_SYNC_BIT = 3;
  localparam int CTRL_STRONG_BIT = 2;
  localparam int POWER_OFF_LSB = 2;
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [7:0] POWER_OFF_RESET = 8'h00;
  localparam logic [13:0] FRAME_RESET = 14'h0000;
  localparam logic SYNC_RESET = 1'b0;
  localparam logic STRONG_RESET = 1'b0;
endpackage

// ===== bit_sync.sv
// Purpose: two-stage synchroniser for slow levels crossing into a clock domain
// Assumes: each bit is an independent level
// Notes: the first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] hold_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= {W{RST_VAL}};
      hold_q <= {W{RST_VAL}};
    end else begin
      meta_q <= d_i;
      hold_q <= meta_q;
    end
  end

  assign q_o = hold_q;
endmodule
`default_nettype wire

// ===== frame_shifter.sv
// Purpose: serial shift register on the link clock
// Assumes: data sampled on rising serial clock edges, first bit is frame bit 13
// Notes: not cleared by the control reset bit, only by the link reset
`timescale 1ns/100ps
`default_nettype none
module frame_shifter (
  // link clock and reset
  input wire logic sclk_i,
  input wire logic rst_i,
  // serial data
  input wire logic sdi_i,
  output logic sdo_o,
  // parallel frame
  output logic [dac_ctrl_pkg::FRAME_W-1:0] frame_o
);
  import dac_ctrl_pkg::*;

  logic [FRAME_W-1:0] shift_q;
  logic [FRAME_W-1:0] shift_d;

  // msb first: after fourteen edges bit 13 sits at the top
  assign shift_d = {shift_q[FRAME_W-2:0], sdi_i}; // [R1] [R21] [R22]

  always_ff @(posedge sclk_i) begin
    if (rst_i) begin
      shift_q <= FRAME_RESET;
    end else begin
      shift_q <= shift_d;
    end
  end

  assign frame_o = shift_q;
  // last stage drives the cascade output
  assign sdo_o = shift_q[FRAME_W-1]; // [R22]
endmodule
`default_nettype wire

// ===== octal_dac_serial_control.sv
// Purpose: digital control of an eight-channel ten-bit converter over a three-wire link
// Assumes: host keeps the serial clock idle while the load strobe is high
// Notes: sys_rst_i stands for the power-on reset
// Behaviour
// [R1] fourteen-bit shift register receives each frame
// [R2] four address bits then ten payload bits
// [R3] address read with bit 13 as lsb
// [R4] address nine power-off, ten control
// [R5] other addresses write nothing
// [R6] payload code passed unchanged to converter
// [R7] staged and active register per channel
// [R8] power-off bits 9..2 map channels 8..1
// [R9] power-off register cannot be read back
// [R10] all channels off also powers bias off
// [R11] control bits reset, update, sync, strong pull-down
// [R12] reset bit clears all but shift register
// [R13] next frame after reset works normally
// [R14] strong pull-down only on powered-down channels
// [R15] sync mode writes staged register only
// [R16] sync mode channel eight write commits all
// [R17] immediate mode writes staged and active
// [R18] update bit commits all staged codes
// [R19] host sequence for simultaneous update
// [R20] host shifts fourteen bits before strobe
// [R21] data captured on rising serial clock
// [R22] msb first, last stage feeds cascade
// [R23] power-on reset clears codes and registers
`timescale 1ns/100ps
`default_nettype none
module octal_dac_serial_control (
  // system clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // three-wire serial link
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic load_strobe_i,
  output logic sdo_o,
  // converter codes, channel one in the low bits
  output logic [dac_ctrl_pkg::NCH*dac_ctrl_pkg::PAY_W-1:0] chan_code_o,
  // power and pull-down controls
  output logic [dac_ctrl_pkg::NCH-1:0] chan_off_bit_o,
  output logic bias_off_o,
  output logic [dac_ctrl_pkg::NCH-1:0] strong_pulldown_o,
  output logic [dac_ctrl_pkg::NCH-1:0] weak_pulldown_o,
  // mode status
  output logic sync_mode_o,
  output logic strong_pulldown_enable_o
);
  import dac_ctrl_pkg::*;

  // link side reset and shift register
  logic link_rst;
  logic [FRAME_W-1:0] shift_frame;

  bit_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_link_rst_sync (
    .clk_i(sclk_i),
    .rst_i(1'b0),
    .d_i(sys_rst_i),
    .q_o(link_rst)
  );

  frame_shifter u_shifter (
    .sclk_i(sclk_i),
    .rst_i(link_rst),
    .sdi_i(sdi_i),
    .sdo_o(sdo_o),
    .frame_o(shift_frame)
  );

  // load strobe crossing into the system domain
  logic load_sync;
  logic load_prev_q;
  logic load_rise;

  bit_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_load_sync (
    .clk_i(clk_i),
    .rst_i(sys_rst_i),
    .d_i(load_strobe_i),
    .q_o(load_sync)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_prev_q <= 1'b0;
    end else begin
      load_prev_q <= load_sync;
    end
  end

  // the frame is quasi-static once the strobe has risen, so it is read as a word
  // on the third rising system clock edge after the strobe edge; a host that clocks during the strobe breaks this
  assign load_rise = load_sync & ~load_prev_q; // [R20]

  // frame decode
  logic [ADDR_W-1:0] addr;
  logic [PAY_W-1:0] payload;
  logic addr_is_chan;
  logic [CHAN_SEL_W-1:0] chan_sel;
  logic [ADDR_W-1:0] chan_ofs;
  logic wr_power;
  logic wr_control;
  logic ctrl_reset;
  logic ctrl_update;
  logic commit_all;
  logic [NCH-1:0] wr_chan;

  // the wire order runs opposite to the value order, so bit 13 lands in the lsb
  genvar ai;
  generate
    for (ai = 0; ai < ADDR_W; ai++) begin : g_addr
      assign addr[ai] = shift_frame[ADDR_LSB_POS-ai]; // [R2] [R3]
    end
  endgenerate
  assign payload = shift_frame[PAY_W-1:0]; // [R2]
  logic addr_is_power;
  logic addr_is_control;

  // codes zero and eleven up match no target, so their strobe writes nothing
  assign addr_is_chan = (addr >= ADDR_CHAN_FIRST) && (addr <= ADDR_CHAN_LAST); // [R3] [R5]
  assign addr_is_power = (addr == ADDR_POWER_OFF); // [R4] [R5]
  assign addr_is_control = (addr == ADDR_CONTROL); // [R4] [R5]
  assign chan_ofs = addr - ADDR_CHAN_FIRST;
  assign chan_sel = chan_ofs[CHAN_SEL_W-1:0];
  assign wr_power = load_rise & addr_is_power; // [R4]
  assign wr_control = load_rise & addr_is_control; // [R4]
  assign ctrl_reset = wr_control & payload[CTRL_RESET_BIT]; // [R11] [R12]
  // a reset frame also clears the update request it carries
  assign ctrl_update = wr_control & payload[CTRL_UPDATE_BIT] & ~payload[CTRL_RESET_BIT]; // [R18]

  // control register: reset and update bits are never stored, so they clear themselves
  logic sync_q;
  logic sync_d;
  logic strong_q;
  logic strong_d;

  assign sync_d = ctrl_reset ? SYNC_RESET :
                  wr_control ? payload[CTRL_SYNC_BIT] : sync_q; // [R11] [R12]
  assign strong_d = ctrl_reset ? STRONG_RESET :
                    wr_control ? payload[CTRL_STRONG_BIT] : strong_q; // [R11] [R14]

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_q <= SYNC_RESET; // [R23]
    end else begin
      sync_q <= sync_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      strong_q <= STRONG_RESET; // [R23]
    end else begin
      strong_q <= strong_d;
    end
  end

  logic commit_by_last;
  logic commit_by_update;

  // channel eight write in sync mode commits every channel, itself included
  assign commit_by_last = wr_chan[NCH-1] & sync_q; // [R16]
  assign commit_by_update = ctrl_update; // [R18]
  assign commit_all = commit_by_update | commit_by_last; // [R16] [R18]

  // power-off register, write only: no path returns it to the host
  logic [NCH-1:0] off_q;
  logic [NCH-1:0] off_d;

  assign off_d = ctrl_reset ? POWER_OFF_RESET :
                 wr_power ? payload[POWER_OFF_LSB +: NCH] : off_q; // [R8] [R9] [R12]

  logic bias_off_d;

  // the shared bias only sleeps when no channel needs it
  assign bias_off_d = &off_d; // [R10]

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      off_q <= POWER_OFF_RESET; // [R23]
    end else begin
      off_q <= off_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bias_off_o <= 1'b0;
    end else begin
      bias_off_o <= bias_off_d; // [R10]
    end
  end

  assign chan_off_bit_o = off_q; // [R8]
  assign sync_mode_o = sync_q;
  assign strong_pulldown_enable_o = strong_q;

  // per-channel staging and commit
  logic [PAY_W-1:0] staged_q [NCH];
  logic [PAY_W-1:0] staged_d [NCH];
  logic [PAY_W-1:0] active_q [NCH];
  logic [PAY_W-1:0] active_d [NCH];
  logic [NCH-1:0] imm_wr;
  logic [NCH-1:0] strong_pd_d;
  logic [NCH-1:0] weak_pd_d;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      assign wr_chan[gi] = load_rise & addr_is_chan & (chan_sel == CHAN_SEL_W'(gi)); // [R3]

      assign staged_d[gi] = ctrl_reset ? CODE_RESET :
                            wr_chan[gi] ? payload : staged_q[gi]; // [R7] [R15] [R12]

      // immediate writes go straight through; commits take the freshly staged value
      assign imm_wr[gi] = wr_chan[gi] & ~sync_q; // [R17]
      assign active_d[gi] = ctrl_reset ? CODE_RESET :
                            imm_wr[gi] ? payload : // [R17]
                            commit_all ? staged_d[gi] : active_q[gi]; // [R15] [R16] [R18]

      // built from next values so the pull-downs move in the cycle the off bits move
      assign strong_pd_d[gi] = off_d[gi] & strong_d; // [R14]
      assign weak_pd_d[gi] = off_d[gi] & ~strong_d; // [R14]

      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          staged_q[gi] <= CODE_RESET; // [R23]
        end else begin
          staged_q[gi] <= staged_d[gi];
        end
      end

      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          active_q[gi] <= CODE_RESET; // [R23]
        end else begin
          active_q[gi] <= active_d[gi]; // [R13]
        end
      end

      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          strong_pulldown_o[gi] <= 1'b0;
        end else begin
          strong_pulldown_o[gi] <= strong_pd_d[gi]; // [R14]
        end
      end

      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          weak_pulldown_o[gi] <= 1'b0;
        end else begin
          weak_pulldown_o[gi] <= weak_pd_d[gi]; // [R14]
        end
      end

      // code drives the resistor string unchanged, straight binary
      assign chan_code_o[gi*PAY_W +: PAY_W] = active_q[gi]; // [R6]
    end
  endgenerate
endmodule
`default_nettype wire

// ===== dac_ctrl_checker.sv
// Purpose: port checks of the converter control block
// Assumes: strobe pulses last several clk cycles
// Notes: bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module dac_ctrl_checker (
  // clocks and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk_i,
  // link
  input wire logic sdi_i,
  input wire logic load_strobe_i,
  input wire logic sdo_o,
  // outputs
  input wire logic [dac_ctrl_pkg::NCH*dac_ctrl_pkg::PAY_W-1:0] chan_code_o,
  input wire logic [dac_ctrl_pkg::NCH-1:0] chan_off_bit_o,
  input wire logic bias_off_o,
  input wire logic [dac_ctrl_pkg::NCH-1:0] strong_pulldown_o,
  input wire logic [dac_ctrl_pkg::NCH-1:0] weak_pulldown_o,
  input wire logic sync_mode_o,
  input wire logic strong_pulldown_enable_o
);
  import dac_ctrl_pkg::*;
  // shift history is unknown until fourteen edges have passed
  logic [3:0] n_q = 4'h0;
  always_ff @(posedge sclk_i) if (n_q != 4'hF) n_q <= n_q + 4'h1;
  sequence s_quiet; !load_strobe_i [*6]; endsequence
  property p_hold; @(posedge clk_i) disable iff (sys_rst_i) s_quiet |->
    $stable({chan_code_o, chan_off_bit_o, sync_mode_o, strong_pulldown_enable_o}); endproperty
  a_hold: assert property (p_hold) else $error("state moved without strobe");
  property p_rose; @(posedge clk_i) disable iff (sys_rst_i)
    $rose(load_strobe_i) |=> $stable(chan_code_o); endproperty
  a_rose: assert property (p_rose) else $error("codes moved too early");
  property p_rst; @(posedge clk_i)
    sys_rst_i |=> chan_code_o == '0 && chan_off_bit_o == '0 && !sync_mode_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_bias; @(posedge clk_i) disable iff (sys_rst_i)
    bias_off_o == &chan_off_bit_o; endproperty
  a_bias: assert property (p_bias) else $error("bias control wrong");
  property p_strong; @(posedge clk_i) disable iff (sys_rst_i)
    strong_pulldown_o == (chan_off_bit_o & {NCH{strong_pulldown_enable_o}}); endproperty
  a_strong: assert property (p_strong) else $error("strong pull-down wrong");
  property p_weak; @(posedge clk_i) disable iff (sys_rst_i)
    weak_pulldown_o == (chan_off_bit_o & ~{NCH{strong_pulldown_enable_o}}); endproperty
  a_weak: assert property (p_weak) else $error("weak pull-down wrong");
  property p_off; @(posedge clk_i) disable iff (sys_rst_i)
    (strong_pulldown_o | weak_pulldown_o) == chan_off_bit_o; endproperty
  a_off: assert property (p_off) else $error("pull-down on live channel");
  property p_sdo; @(posedge sclk_i) disable iff (sys_rst_i)
    n_q == 4'hF |-> sdo_o == $past(sdi_i, 14); endproperty
  a_sdo: assert property (p_sdo) else $error("cascade out wrong");
endmodule
bind octal_dac_serial_control dac_ctrl_checker dac_ctrl_checker_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .sdi_i(sdi_i),
  .load_strobe_i(load_strobe_i), .sdo_o(sdo_o), .chan_code_o(chan_code_o),
  .chan_off_bit_o(chan_off_bit_o), .bias_off_o(bias_off_o),
  .strong_pulldown_o(strong_pulldown_o), .weak_pulldown_o(weak_pulldown_o),
  .sync_mode_o(sync_mode_o), .strong_pulldown_enable_o(strong_pulldown_enable_o));
`default_nettype wire

// ===== host_link_model.sv
// Purpose: host side of the three-wire link
// Assumes: caller orders the frame bits
// Notes: serial clock rests low between frames
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
  // link pins
  output var logic sclk_o,
  output var logic sdi_o,
  output var logic load_strobe_o
);
  initial begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  task automatic send(input logic [13:0] f);
    #3;
    for (int i = 13; i >= 0; i--) begin
      sdi_o <= f[i];
      #16 sclk_o <= 1'b1;
      #16 sclk_o <= 1'b0;
    end
    sdi_o <= ~f[0]; // released line must not echo the last bit
    #50 load_strobe_o <= 1'b1;
    #60 load_strobe_o <= 1'b0;
    #60;
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench of the converter control
// Assumes: link driven by the host model
// Notes: expected state kept in a shadow model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dac_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  wire logic sclk_i, sdi_i, load_strobe_i, sync_mode_o, strong_pulldown_enable_o;
  wire logic [NCH*PAY_W-1:0] chan_code_o;
  wire logic [NCH-1:0] chan_off_bit_o;
  wire logic sdo_o, bias_off_o;
  wire logic [NCH-1:0] strong_pulldown_o, weak_pulldown_o;
  logic [NCH*PAY_W-1:0] e_code, e_stg;
  logic [NCH-1:0] e_off;
  logic e_sy, e_st;
  int err_total = 0;
  int samples_checked = 0;
  always #5 clk_i = ~clk_i;
  host_link_model host_link_model_i (.sclk_o(sclk_i), .sdi_o(sdi_i),
    .load_strobe_o(load_strobe_i));
  octal_dac_serial_control octal_dac_serial_control_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .sdi_i(sdi_i), .load_strobe_i(load_strobe_i),
    .sdo_o(sdo_o), .chan_code_o(chan_code_o), .chan_off_bit_o(chan_off_bit_o),
    .bias_off_o(bias_off_o), .strong_pulldown_o(strong_pulldown_o),
    .weak_pulldown_o(weak_pulldown_o), .sync_mode_o(sync_mode_o),
    .strong_pulldown_enable_o(strong_pulldown_enable_o));
  task automatic chk(input logic [3:0] a);
    samples_checked++;
    if ({chan_code_o, chan_off_bit_o, sync_mode_o, strong_pulldown_enable_o}
        !== {e_code, e_off, e_sy, e_st}) begin
      err_total++;
      $display("[ERR] %0t state wrong after address %h", $time, a);
    end
    samples_checked++;
    if ({bias_off_o, strong_pulldown_o, weak_pulldown_o}
        !== {&e_off, e_off & {NCH{e_st}}, e_off & ~{NCH{e_st}}}) begin
      err_total++;
      $display("[ERR] %0t pull-down or bias wrong after address %h", $time, a);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [9:0] p);
    int k;
    k = (int'(a) - 1) * PAY_W;
    host_link_model_i.send({a[0], a[1], a[2], a[3], p});
    if (a >= ADDR_CHAN_FIRST && a <= ADDR_CHAN_LAST) begin
      e_stg[k +: 10] = p;
      if (!e_sy) e_code[k +: 10] = p;
      else if (a == ADDR_CHAN_LAST) e_code = e_stg;
    end
    if (a == ADDR_POWER_OFF) e_off = p[9:2];
    if (a == ADDR_CONTROL && p[CTRL_RESET_BIT]) {e_code, e_stg, e_off, e_sy, e_st} = '0;
    else if (a == ADDR_CONTROL) begin
      {e_sy, e_st} = {p[CTRL_SYNC_BIT], p[CTRL_STRONG_BIT]};
      if (p[CTRL_UPDATE_BIT]) e_code = e_stg;
    end
    repeat (6) @(posedge clk_i);
    chk(a);
    samples_checked++;
    if (sdo_o !== a[0]) begin
      err_total++;
      $display("[ERR] %0t cascade out wrong after address %h", $time, a);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {e_code, e_stg, e_off, e_sy, e_st} = '0;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(4'h0);
    for (int i = 1; i <= 8; i++) wr(4'(i), 10'(i * 146 - 145));
    wr(4'h1, 10'h000);
    for (int a = 11; a <= 16; a++) wr(4'(a), 10'h2AA);
    wr(4'h9, 10'h3FF);
    wr(4'hA, 10'h004);
    wr(4'h9, 10'h00B);
    wr(4'hA, 10'h008);
    for (int i = 1; i <= 8; i++) wr(4'(i), 10'(i * 9));
    wr(4'h3, 10'h1F0);
    wr(4'hA, 10'h018);
    wr(4'h5, 10'h0F0);
    wr(4'hA, 10'h010);
    wr(4'hA, 10'h03C);
    wr(4'h4, 10'h155);
    wr(4'hA, 10'h010);
    wrap_up();
  end
endmodule
`default_nettype wire
